// ### rtl/scsm_regs.vh
/*
 Constants of the serial controller SPI master: mode code, word size, divider and FIFO figures.
 Assumes inclusion by bare name from the design files of this block; definitions only.
*/
// Function
// - Controller acts only as master and shifts exactly eight-bit words.
// - Serial rate is 24 MHz over two times (linear+1) times two to exponent.
// - Linear and exponent fields take 0 to 15, giving 12 Mbps to 22.9 bps.
// - Polarity, phase and order bits shape the frame; order one means LSB first.
// - Bytes pass through separate four-entry transmit and receive FIFOs.
// - Transmit idle clears on write to empty FIFO, sets when all shifted out.
// - Transmit space clears when FIFO full, sets once one byte shifts out.
// - Receive valid is set while the receive FIFO holds an unread byte.
// - With four unread bytes, new bytes drop, overflow flag and overrun event raised; the code drops only at six (FIFO plus two-entry buffer).
// - DMA overrun error shows only after receive FIFO drains; FIFO event immediate.
// - DMA error clears only by channel reset bit or loading an unloaded buffer.
// - A byte is received only while a byte is being transmitted.
// - Empty FIFO with repeat on: resend last byte or busy token 0xFF.
// - Each automatic byte start counts as transmit underrun and raises its flag.
// - With automatic transmission off, reception stops and held bytes remain.
// - Events on rising idle, space, valid; falling DMA active; overrun; underrun.
`ifndef SCSM_REGS_VH
`define SCSM_REGS_VH
`define SCSM_MODE_SPI      2'h2
`define SCSM_WORD_BITS     8
`define SCSM_BUSY_TOKEN    8'hFF
`define SCSM_LAST_EDGE     4'hF
`define SCSM_FIFO_DEPTH    4
`define SCSM_BUF_DEPTH     2
`define SCSM_REF_RATE_MHZ  9'h018
`define SCSM_CORE_RATE_MHZ 9'h0FA
`define SCSM_HALF_WIDTH    20
`endif

// ### rtl/scsm_fifo.v
/*
 Synchronous FIFO with valid and ready on both sides and registered full and empty.
 Assumes one clock, a synchronous reset and a flush from the owner.
*/
`timescale 1ns/1ns
module scsm_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             core_clk,
	input  wire             reset,
	input  wire             clk_en,
	input  wire             flush,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_reg;
	reg  [AW-1:0]    rd_ptr_reg;
	reg  [AW:0]      count_reg;
	reg  [AW:0]      count_next;
	reg              full_reg;
	reg              empty_reg;
	wire             push;
	wire             pop;
	assign push      = in_valid & ~full_reg;
	assign pop       = out_ready & ~empty_reg;
	assign in_ready  = ~full_reg;
	assign out_valid = ~empty_reg;
	assign out_data  = mem[rd_ptr_reg];
	// Full and empty come from the next count so a producer never sees stale room.
	always @*
	begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + {{AW{1'b0}}, 1'b1};
		else if (pop & ~push)
			count_next = count_reg - {{AW{1'b0}}, 1'b1};
	end
	always @(posedge core_clk)
	begin
		if (reset | (clk_en & flush))
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			full_reg   <= 1'b0;
			empty_reg  <= 1'b1;
		end
		else if (clk_en)
		begin
			if (push)
			begin
				mem[wr_ptr_reg] <= in_data;
				wr_ptr_reg      <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			count_reg <= count_next;
			full_reg  <= (count_next == DEPTH);
			empty_reg <= (count_next == {(AW+1){1'b0}});
		end
	end
endmodule // scsm_fifo

// ### rtl/scsm_clkdiv.v
/*
 Serial clock divider: a 24 MHz reference tick made from the core clock, then a half-bit timer.
 Assumes a 250 MHz core clock; the timer restarts whenever run is low.
*/
`timescale 1ns/1ns
`include "scsm_regs.vh"
module scsm_clkdiv (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       clk_en,
	input  wire       run,
	input  wire [3:0] divider_linear,
	input  wire [3:0] divider_exponent,
	output reg        half_tick
);
	reg  [8:0]                  acc_reg;
	reg  [`SCSM_HALF_WIDTH-1:0] half_cnt_reg;
	wire [8:0]                  acc_sum;
	wire                        ref_tick;
	wire [`SCSM_HALF_WIDTH-1:0] half_target;
	// The reference tick jitters by one core cycle; the average rate is exact.
	assign acc_sum     = acc_reg + `SCSM_REF_RATE_MHZ;
	assign ref_tick    = (acc_sum >= `SCSM_CORE_RATE_MHZ);
	assign half_target = {{(`SCSM_HALF_WIDTH-4){1'b0}}, divider_linear} + {{(`SCSM_HALF_WIDTH-1){1'b0}}, 1'b1};
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			acc_reg      <= 9'h000;
			half_cnt_reg <= {`SCSM_HALF_WIDTH{1'b0}};
			half_tick    <= 1'b0;
		end
		else if (clk_en)
		begin
			half_tick <= 1'b0;
			if (!run)
			begin
				acc_reg      <= 9'h000;
				half_cnt_reg <= {`SCSM_HALF_WIDTH{1'b0}};
			end
			else
			begin
				acc_reg <= ref_tick ? acc_sum - `SCSM_CORE_RATE_MHZ : acc_sum;
				if (ref_tick)
				begin
					if (half_cnt_reg + {{(`SCSM_HALF_WIDTH-1){1'b0}}, 1'b1} == (half_target << divider_exponent))
					begin
						half_cnt_reg <= {`SCSM_HALF_WIDTH{1'b0}};
						half_tick    <= 1'b1;
					end
					else
						half_cnt_reg <= half_cnt_reg + {{(`SCSM_HALF_WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // scsm_clkdiv

// ### rtl/scsm_master.v
/*
 Serial controller in SPI master mode: FIFOs, serializer, status flags and event pulses.
 Assumes a DMA engine or software on the same clock at the FIFO ports and DMA buffer flags.
*/
`timescale 1ns/1ns
`include "scsm_regs.vh"
module scsm_master (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       clk_en,
	input  wire [1:0] serial_ctrl_function_select,
	input  wire       master_enable_bit,
	input  wire       bit_order_select,
	input  wire       clock_phase_select,
	input  wire       clock_polarity_select,
	input  wire       auto_tx_enable,
	input  wire       repeat_or_token_select,
	input  wire [3:0] divider_linear,
	input  wire [3:0] divider_exponent,
	input  wire       tx_wr_valid,
	input  wire [7:0] tx_wr_data,
	output reg        tx_wr_ready,
	output reg        rx_rd_valid,
	output reg  [7:0] rx_rd_data,
	input  wire       rx_rd_ready,
	input  wire       receive_overflow_clear,
	input  wire [1:0] tx_buffer_active_flags,
	input  wire [1:0] rx_buffer_active_flags,
	input  wire [1:0] dma_channel_reset_bits,
	input  wire       tx_buffer_load,
	input  wire       rx_buffer_load,
	input  wire       controller_data_in,
	output reg        controller_data_out,
	output reg        spi_clk_out,
	output reg        transmit_idle_flag,
	output reg        transmit_space_flag,
	output reg        receive_valid_flag,
	output reg        receive_overflow_flag,
	output reg        tx_dma_error,
	output reg        rx_dma_error,
	output reg        tx_idle_event,
	output reg        tx_space_event,
	output reg        rx_valid_event,
	output reg        tx_buffer_done_event,
	output reg        rx_buffer_done_event,
	output reg        receive_overrun_irq,
	output reg        transmit_underrun_irq_flag
);
	localparam ST_IDLE  = 2'b01;
	localparam ST_SHIFT = 2'b10;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function [7:0] shift_in;
		input [7:0] sr;
		input       lsb_first;
		input       bit_in;
		begin
			shift_in = lsb_first ? {bit_in, sr[7:1]} : {sr[6:0], bit_in};
		end
	endfunction

	function out_bit;
		input [7:0] sr;
		input       lsb_first;
		begin
			out_bit = lsb_first ? sr[0] : sr[7];
		end
	endfunction

	reg  [1:0] st_reg;
	reg  [3:0] edge_cnt_reg;
	reg  [7:0] tx_sr_reg;
	reg  [7:0] rx_sr_reg;
	reg  [7:0] last_byte_reg;
	reg        din_meta_reg;
	reg        din_sync_reg;
	reg        rx_push_reg;
	reg        ovf_pending_reg;
	reg  [1:0] tx_act_prev_reg;
	reg  [1:0] rx_act_prev_reg;
	wire       enabled;
	wire       half_tick;
	wire       leading;
	wire       do_sample;
	wire       do_shift;
	wire       tx_valid;
	wire [7:0] tx_data;
	wire       tx_pop;
	wire       rx_fifo_ready;
	wire       rx_fifo_valid;
	wire [7:0] rx_fifo_data;
	wire       buf_ready;
	wire       buf_valid;
	wire [7:0] buf_data;
	wire       tx_ready;
	wire       overrun;
	wire       idle_next;
	wire       valid_next;

	assign enabled   = (serial_ctrl_function_select == `SCSM_MODE_SPI) & master_enable_bit;
	assign leading   = ~edge_cnt_reg[0];
	assign do_sample = half_tick & (leading ^ clock_phase_select);
	assign do_shift  = half_tick & (clock_phase_select ? (leading & (edge_cnt_reg != 4'h0))
		: (~leading & (edge_cnt_reg != `SCSM_LAST_EDGE)));
	assign tx_pop    = enabled & st_reg[0] & tx_valid;
	assign overrun   = rx_push_reg & ~rx_fifo_ready;
	assign idle_next = ~tx_valid & st_reg[0];
	assign valid_next = rx_fifo_valid | buf_valid;

	// ---------------------------------------------------------------
	// FIFOs and output buffer
	// ---------------------------------------------------------------
	// Leaving the SPI mode flushes both FIFOs; this is the reinitialisation path.
	scsm_fifo #(.WIDTH(`SCSM_WORD_BITS), .DEPTH(`SCSM_FIFO_DEPTH), .AW(2)) u_tx_fifo (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.flush    (~enabled),
		.in_valid (tx_wr_valid & tx_wr_ready),
		.in_data  (tx_wr_data),
		.in_ready (tx_ready),
		.out_valid(tx_valid),
		.out_ready(tx_pop),
		.out_data (tx_data)
	);

	scsm_fifo #(.WIDTH(`SCSM_WORD_BITS), .DEPTH(`SCSM_FIFO_DEPTH), .AW(2)) u_rx_fifo (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.flush    (~enabled),
		.in_valid (rx_push_reg),
		.in_data  (rx_sr_reg),
		.in_ready (rx_fifo_ready),
		.out_valid(rx_fifo_valid),
		.out_ready(buf_ready),
		.out_data (rx_fifo_data)
	);

	// The small buffer holds words while the reader stalls, so none is dropped there.
	scsm_fifo #(.WIDTH(`SCSM_WORD_BITS), .DEPTH(`SCSM_BUF_DEPTH), .AW(1)) u_rx_buf (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.flush    (~enabled),
		.in_valid (rx_fifo_valid),
		.in_data  (rx_fifo_data),
		.in_ready (buf_ready),
		.out_valid(buf_valid),
		.out_ready(rx_rd_ready & rx_rd_valid),
		.out_data (buf_data)
	);

	scsm_clkdiv u_clkdiv (
		.core_clk        (core_clk),
		.reset           (reset),
		.clk_en          (clk_en),
		.run             (st_reg[1]),
		.divider_linear  (divider_linear),
		.divider_exponent(divider_exponent),
		.half_tick       (half_tick)
	);

	// ---------------------------------------------------------------
	// Serializer
	// ---------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			din_meta_reg <= controller_data_in;
			din_sync_reg <= din_meta_reg;
		end
	end

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			st_reg                     <= ST_IDLE;
			edge_cnt_reg               <= 4'h0;
			tx_sr_reg                  <= 8'h00;
			rx_sr_reg                  <= 8'h00;
			last_byte_reg              <= 8'h00;
			rx_push_reg                <= 1'b0;
			transmit_underrun_irq_flag <= 1'b0;
			controller_data_out        <= 1'b0;
			spi_clk_out                <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_push_reg                <= 1'b0;
			transmit_underrun_irq_flag <= 1'b0;
			controller_data_out        <= out_bit(tx_sr_reg, bit_order_select);
			case (st_reg)
				ST_IDLE:
				begin
					spi_clk_out  <= clock_polarity_select;
					edge_cnt_reg <= 4'h0;
					if (enabled & tx_valid)
					begin
						tx_sr_reg     <= tx_data;
						last_byte_reg <= tx_data;
						st_reg        <= ST_SHIFT;
					end
					else if (enabled & auto_tx_enable)
					begin
						tx_sr_reg                  <= repeat_or_token_select ? last_byte_reg : `SCSM_BUSY_TOKEN;
						transmit_underrun_irq_flag <= 1'b1;
						st_reg                     <= ST_SHIFT;
					end
				end
				ST_SHIFT:
				begin
					if (!enabled)
						st_reg <= ST_IDLE;
					else if (half_tick)
					begin
						spi_clk_out  <= ~spi_clk_out;
						edge_cnt_reg <= edge_cnt_reg + 4'h1;
						if (do_sample)
							rx_sr_reg <= shift_in(rx_sr_reg, bit_order_select, din_sync_reg);
						if (do_shift)
							tx_sr_reg <= shift_in(tx_sr_reg, bit_order_select, 1'b0);
						if (edge_cnt_reg == `SCSM_LAST_EDGE)
						begin
							rx_push_reg <= 1'b1;
							st_reg      <= ST_IDLE;
						end
					end
				end
				default:
					st_reg <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Flags, DMA errors and events
	// ---------------------------------------------------------------
	// Overflow set wins over a clear in the same cycle.
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			tx_wr_ready           <= 1'b0;
			rx_rd_valid           <= 1'b0;
			rx_rd_data            <= 8'h00;
			transmit_idle_flag    <= 1'b1;
			transmit_space_flag   <= 1'b1;
			receive_valid_flag    <= 1'b0;
			receive_overflow_flag <= 1'b0;
			ovf_pending_reg       <= 1'b0;
			tx_dma_error          <= 1'b0;
			rx_dma_error          <= 1'b0;
			tx_idle_event         <= 1'b0;
			tx_space_event        <= 1'b0;
			rx_valid_event        <= 1'b0;
			tx_buffer_done_event  <= 1'b0;
			rx_buffer_done_event  <= 1'b0;
			receive_overrun_irq   <= 1'b0;
			tx_act_prev_reg       <= 2'h0;
			rx_act_prev_reg       <= 2'h0;
		end
		else if (clk_en)
		begin
			// Ready rests one cycle after each take because it is registered from the full flag and so trails a write by one cycle.
			tx_wr_ready         <= tx_ready & enabled & ~(tx_wr_valid & tx_wr_ready);
			rx_rd_valid         <= buf_valid & ~(rx_rd_valid & rx_rd_ready);
			rx_rd_data          <= buf_data;
			transmit_idle_flag  <= idle_next & ~tx_pop;
			transmit_space_flag <= tx_ready;
			receive_valid_flag  <= valid_next;
			tx_idle_event       <= idle_next & ~tx_pop & ~transmit_idle_flag;
			tx_space_event      <= tx_ready & ~transmit_space_flag;
			rx_valid_event      <= valid_next & ~receive_valid_flag;
			tx_act_prev_reg     <= tx_buffer_active_flags;
			rx_act_prev_reg     <= rx_buffer_active_flags;
			tx_buffer_done_event <= |(tx_act_prev_reg & ~tx_buffer_active_flags);
			rx_buffer_done_event <= |(rx_act_prev_reg & ~rx_buffer_active_flags);
			receive_overrun_irq  <= overrun;
			if (overrun)
				receive_overflow_flag <= 1'b1;
			else if (receive_overflow_clear)
				receive_overflow_flag <= 1'b0;
			if (overrun & (|rx_buffer_active_flags))
				ovf_pending_reg <= 1'b1;
			else if (dma_channel_reset_bits[1] | rx_buffer_load | (ovf_pending_reg & ~valid_next & ~rx_rd_valid))
				ovf_pending_reg <= 1'b0;
			if (ovf_pending_reg & ~valid_next & ~rx_rd_valid)
				rx_dma_error <= 1'b1;
			else if (dma_channel_reset_bits[1] | rx_buffer_load)
				rx_dma_error <= 1'b0;
			if (transmit_underrun_irq_flag & (|tx_buffer_active_flags))
				tx_dma_error <= 1'b1;
			else if (dma_channel_reset_bits[0] | tx_buffer_load)
				tx_dma_error <= 1'b0;
		end
	end
endmodule // scsm_master

// ### tb/scsm_props.sv
/*
 Port checker of the SPI master: clock idle level, bit timing, flags and event pulses.
 Assumes one core clock, a synchronous reset and a bind onto scsm_master.
*/
`timescale 1ns/1ns
module scsm_props (
	input wire       core_clk,
	input wire       reset,
	input wire       clock_polarity_select,
	input wire       auto_tx_enable,
	input wire       tx_wr_valid,
	input wire       tx_wr_ready,
	input wire       rx_rd_valid,
	input wire [7:0] rx_rd_data,
	input wire       rx_rd_ready,
	input wire       receive_overflow_clear,
	input wire       spi_clk_out,
	input wire       transmit_idle_flag,
	input wire       transmit_space_flag,
	input wire       receive_valid_flag,
	input wire       receive_overflow_flag,
	input wire       tx_idle_event,
	input wire       tx_space_event,
	input wire       rx_valid_event,
	input wire       receive_overrun_irq,
	input wire       transmit_underrun_irq_flag
);
	// ----
	// Checks
	// ----
	// An automatic frame may still finish after the enable drops, so wait for this to saturate.
	reg [9:0] quiet_reg;
	always @(posedge core_clk)
		if (reset || auto_tx_enable)
			quiet_reg <= 10'h000;
		else if (quiet_reg != 10'h3FF)
			quiet_reg <= quiet_reg + 10'h001;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	idle_level_a: assert property ((transmit_idle_flag && quiet_reg == 10'h3FF && !$past(reset)
		&& $stable(clock_polarity_select)) |-> spi_clk_out == clock_polarity_select) else $error("bad idle level");
	rate_floor_a: assert property (($changed(spi_clk_out) && !$past(reset)) |=> $stable(spi_clk_out) [*8])
		else $error("half bit too short");
	idle_drop_a: assert property ((tx_wr_valid && tx_wr_ready && transmit_idle_flag && quiet_reg == 10'h3FF)
		|-> ##[1:3] !transmit_idle_flag) else $error("idle kept after write");
	idle_event_a: assert property ($rose(transmit_idle_flag) |-> ##[0:1] tx_idle_event)
		else $error("no idle event");
	space_event_a: assert property ($rose(transmit_space_flag) |-> ##[0:1] tx_space_event)
		else $error("no space event");
	valid_event_a: assert property ($rose(receive_valid_flag) |-> ##[0:1] rx_valid_event)
		else $error("no valid event");
	overrun_flag_a: assert property (receive_overrun_irq |-> ##[0:1] receive_overflow_flag)
		else $error("overrun without flag");
	overflow_hold_a: assert property ((receive_overflow_flag && !receive_overflow_clear) |=> receive_overflow_flag)
		else $error("overflow flag lost");
	underrun_cause_a: assert property (transmit_underrun_irq_flag |-> (auto_tx_enable || $past(auto_tx_enable)
		|| $past(auto_tx_enable, 2))) else $error("underrun without auto send");
	rx_hold_a: assert property ((rx_rd_valid && !rx_rd_ready) |=> (rx_rd_valid && $stable(rx_rd_data)))
		else $error("read word not held");
	cover property (receive_overrun_irq);
	cover property (transmit_underrun_irq_flag);
	cover property (tx_space_event);
endmodule // scsm_props
bind scsm_master scsm_props u_props (.core_clk, .reset, .clock_polarity_select, .auto_tx_enable, .tx_wr_valid,
	.tx_wr_ready, .rx_rd_valid, .rx_rd_data, .rx_rd_ready, .receive_overflow_clear, .spi_clk_out,
	.transmit_idle_flag, .transmit_space_flag, .receive_valid_flag, .receive_overflow_flag, .tx_idle_event,
	.tx_space_event, .rx_valid_event, .receive_overrun_irq, .transmit_underrun_irq_flag);

// ### tb/scsm_slave_model.sv
/*
 Behavioural SPI slave: answers reply_byte and records the byte it hears.
 Assumes whole frames of sixteen clock edges and a steady configuration within a frame.
*/
`timescale 1ns/1ns
module scsm_slave_model (
	input  wire       core_clk,
	input  wire       spi_clk_out,
	input  wire       controller_data_out,
	input  wire       clock_polarity_select,
	input  wire       clock_phase_select,
	input  wire       bit_order_select,
	input  wire [7:0] reply_byte,
	output reg        controller_data_in,
	output reg  [7:0] got_byte,
	output reg  [7:0] got_count
);
	// ----
	// Slave
	// ----
	reg  [3:0] edges_reg;
	reg  [7:0] shift_reg;
	reg        noise_reg;
	wire [3:0] edges_m1 = edges_reg - 4'h1;
	wire [2:0] idx      = clock_phase_select ? edges_m1[3:1] : edges_reg[3:1];
	initial
	begin
		edges_reg = 4'h0;
		noise_reg = 1'b0;
		got_count = 8'h00;
	end
	// The line is always answered: no select exists, so this slave is always addressed.
	always @(posedge core_clk)
		noise_reg <= ~noise_reg;
	// Before the leading edge in phase one the line is undriven, so it shows a changing pattern.
	always @*
		if (edges_reg == 4'h0 && clock_phase_select)
			controller_data_in = noise_reg;
		else
			controller_data_in = bit_order_select ? reply_byte[idx] : reply_byte[3'h7 - idx];
	// A move to the idle level between frames is a polarity change, not a clock edge.
	always @(spi_clk_out)
		if (spi_clk_out !== clock_polarity_select || edges_reg[0])
		begin
			edges_reg = edges_reg + 4'h1;
			if (edges_reg[0] != clock_phase_select)
				shift_reg = bit_order_select ? {controller_data_out, shift_reg[7:1]} : {shift_reg[6:0], controller_data_out};
			if (edges_reg == 4'h0)
			begin
				got_byte = shift_reg;
				got_count = got_count + 8'h01;
			end
		end
endmodule // scsm_slave_model

// ### tb/scsm_master_tb.sv
/*
 Self-checking bench of the SPI master: frame formats, FIFO flow, overflow, repeat, DMA flags, rate.
 Assumes the slave model on the serial pins and the checker bound onto the design.
*/
`timescale 1ns/1ns
module scsm_master_tb;
	reg        core_clk, reset, auto_tx_enable, repeat_or_token_select;
	reg        bit_order_select, clock_phase_select, clock_polarity_select, master_enable_bit;
	reg  [3:0] divider_linear, divider_exponent;
	reg        tx_wr_valid, rx_rd_ready, receive_overflow_clear, tx_buffer_load, rx_buffer_load;
	reg  [1:0] tx_buffer_active_flags, rx_buffer_active_flags, dma_channel_reset_bits;
	reg  [7:0] tx_wr_data, reply_byte, under_cnt;
	wire       tx_wr_ready, rx_rd_valid, controller_data_in, controller_data_out, spi_clk_out;
	wire       transmit_idle_flag, transmit_space_flag, receive_valid_flag, receive_overflow_flag;
	wire       tx_dma_error, rx_dma_error, rx_buffer_done_event, transmit_underrun_irq_flag, tx_buffer_done_event;
	wire [7:0] rx_rd_data, got_byte, got_count;
	integer    num_errors, n_tests, cycles;
	// ----
	// Harness
	// ----
	scsm_master dut (.core_clk, .reset, .clk_en(1'b1), .serial_ctrl_function_select(2'h2),
		.master_enable_bit, .bit_order_select, .clock_phase_select, .clock_polarity_select,
		.auto_tx_enable, .repeat_or_token_select, .divider_linear, .divider_exponent, .tx_wr_valid,
		.tx_wr_data, .tx_wr_ready, .rx_rd_valid, .rx_rd_data, .rx_rd_ready, .receive_overflow_clear,
		.tx_buffer_active_flags, .rx_buffer_active_flags, .dma_channel_reset_bits, .tx_buffer_load,
		.rx_buffer_load, .controller_data_in, .controller_data_out, .spi_clk_out, .transmit_idle_flag,
		.transmit_space_flag, .receive_valid_flag, .receive_overflow_flag, .tx_dma_error, .rx_dma_error,
		.tx_idle_event(), .tx_space_event(), .rx_valid_event(), .tx_buffer_done_event,
		.rx_buffer_done_event, .receive_overrun_irq(), .transmit_underrun_irq_flag);
	scsm_slave_model slave (.core_clk, .spi_clk_out, .controller_data_out, .clock_polarity_select,
		.clock_phase_select, .bit_order_select, .reply_byte, .controller_data_in, .got_byte, .got_count);
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles = cycles + 1;
		if (transmit_underrun_irq_flag === 1'b1)
			under_cnt = under_cnt + 8'h01;
		if (cycles == 60000)
		begin
			num_errors = num_errors + 1;
			stop_test;
		end
	end
	task check(input [7:0] seen, input [7:0] want);
		if (seen !== want)
		begin
			num_errors = num_errors + 1;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, want);
		end
		else
			n_tests = n_tests + 1;
	endtask
	task stop_test;
		begin
			if (num_errors == 0 && n_tests > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task step;
		begin
			@(posedge core_clk);
			#1;
		end
	endtask
	// Leaves valid high so back-to-back writes never lower and raise it in one time step.
	task wr(input [7:0] b);
		integer k;
		begin
			tx_wr_valid = 1'b1;
			tx_wr_data = b;
			k = 0;
			@(posedge core_clk);
			while (tx_wr_ready !== 1'b1 && k < 3000)
			begin
				k = k + 1;
				@(posedge core_clk);
			end
			#1;
		end
	endtask
	task wait_idle;
		integer k;
		begin
			tx_wr_valid = 1'b0;
			k = 0;
			repeat (4) @(posedge core_clk);
			while (transmit_idle_flag !== 1'b1 && k < 20000)
			begin
				k = k + 1;
				@(posedge core_clk);
			end
			repeat (8) @(posedge core_clk);
			#1;
		end
	endtask
	task drain(input [7:0] want, output integer n);
		integer k;
		begin
			n = 0;
			rx_rd_ready = 1'b1;
			for (k = 0; k < 16; k = k + 1)
			begin
				@(posedge core_clk);
				if (rx_rd_valid === 1'b1)
				begin
					n = n + 1;
					check(rx_rd_data, want);
				end
			end
			#1;
			rx_rd_ready = 1'b0;
		end
	endtask
	// ----
	// Scenarios
	// ----
	// Polarity only ever rises here, so no stray byte can precede a frame.
	task t_modes;
		integer i, n;
		for (i = 0; i < 8; i = i + 1)
		begin
			{clock_polarity_select, clock_phase_select, bit_order_select} = i[2:0];
			reply_byte = 8'h35 ^ i[7:0];
			step;
			step;
			wr(8'hB1 + i[7:0]);
			wait_idle;
			check(got_byte, 8'hB1 + i[7:0]);
			drain(8'h35 ^ i[7:0], n);
			check(n[7:0], 8'h01);
		end
	endtask
	task t_fill;
		integer i, n;
		begin
			reply_byte = 8'h6B;
			rx_buffer_active_flags = 2'h1;
			for (i = 0; i < 5; i = i + 1)
				wr(8'h10 + i[7:0]);
			step;
			check({6'h00, transmit_space_flag, tx_wr_ready}, 8'h00);
			for (i = 5; i < 8; i = i + 1)
				wr(8'h10 + i[7:0]);
			wait_idle;
			check({6'h00, receive_valid_flag, receive_overflow_flag}, 8'h03);
			check({7'h00, rx_dma_error}, 8'h00);
			drain(8'h6B, n);
			check({7'h00, n >= 4 && n <= 7}, 8'h01);
			check({7'h00, rx_dma_error}, 8'h01);
			receive_overflow_clear = 1'b1;
			step;
			receive_overflow_clear = 1'b0;
			step;
			check({6'h00, receive_valid_flag, receive_overflow_flag}, 8'h00);
		end
	endtask
	task t_auto;
		integer n;
		reg [7:0] u0, c0;
		begin
			reply_byte = 8'h4E;
			wr(8'hC7);
			wait_idle;
			drain(8'h4E, n);
			repeat_or_token_select = 1'b1;
			u0 = under_cnt;
			tx_buffer_active_flags = 2'h1;
			c0 = got_count;
			auto_tx_enable = 1'b1;
			repeat (600) @(posedge core_clk);
			#1;
			auto_tx_enable = 1'b0;
			repeat (400) @(posedge core_clk);
			#1;
			check(got_byte, 8'hC7);
			check(under_cnt - u0, got_count - c0);
			check({7'h00, tx_dma_error}, 8'h01);
			c0 = got_count;
			repeat (400) @(posedge core_clk);
			#1;
			check(got_count - c0, 8'h00);
			check({7'h00, receive_valid_flag}, 8'h01);
			drain(8'h4E, n);
			repeat_or_token_select = 1'b0;
			auto_tx_enable = 1'b1;
			repeat (400) @(posedge core_clk);
			#1;
			auto_tx_enable = 1'b0;
			repeat (400) @(posedge core_clk);
			#1;
			check(got_byte, 8'hFF);
			drain(8'h4E, n);
		end
	endtask
	task t_dma;
		integer k;
		reg [1:0] seen;
		begin
			seen = 2'h0;
			{tx_buffer_active_flags, rx_buffer_active_flags} = 4'hF;
			step;
			{tx_buffer_active_flags, rx_buffer_active_flags} = 4'h6;
			for (k = 0; k < 4; k = k + 1)
			begin
				@(posedge core_clk);
				seen = seen | {tx_buffer_done_event === 1'b1, rx_buffer_done_event === 1'b1};
			end
			#1;
			check({6'h00, seen}, 8'h03);
			{dma_channel_reset_bits, tx_buffer_load, rx_buffer_load} = 4'hF;
			step;
			{dma_channel_reset_bits, tx_buffer_load, rx_buffer_load, tx_buffer_active_flags} = 6'h00;
			rx_buffer_active_flags = 2'h0;
			step;
			check({6'h00, tx_dma_error, rx_dma_error}, 8'h00);
		end
	endtask
	// Half bit of four reference ticks: fifteen half bits span 2500 ns.
	task t_rate;
		integer n;
		time t0;
		begin
			{divider_linear, divider_exponent} = 8'h11;
			wr(8'h5D);
			tx_wr_valid = 1'b0;
			@(spi_clk_out);
			t0 = $time;
			repeat (15) @(spi_clk_out);
			check({7'h00, ($time - t0) >= 2460 && ($time - t0) <= 2540}, 8'h01);
			wait_idle;
			check(got_byte, 8'h5D);
			drain(8'h4E, n);
			master_enable_bit = 1'b0;
			step;
			check({7'h00, tx_wr_ready}, 8'h00);
		end
	endtask
	initial
	begin
		{num_errors, n_tests, cycles} = 96'h0;
		{under_cnt, reply_byte, tx_wr_data} = 24'h000000;
		{reset, master_enable_bit} = 2'h3;
		{auto_tx_enable, repeat_or_token_select, bit_order_select, clock_phase_select} = 4'h0;
		{clock_polarity_select, divider_linear, divider_exponent} = 9'h000;
		{tx_wr_valid, rx_rd_ready, receive_overflow_clear, tx_buffer_load, rx_buffer_load} = 5'h00;
		{tx_buffer_active_flags, rx_buffer_active_flags, dma_channel_reset_bits} = 6'h00;
		repeat (3) @(posedge core_clk);
		#1;
		reset = 1'b0;
		check({6'h00, transmit_idle_flag, transmit_space_flag}, 8'h03);
		repeat (4) step;
		t_modes;
		t_fill;
		t_auto;
		t_dma;
		t_rate;
		stop_test;
	end
endmodule // scsm_master_tb
